// ### design/ebrg_pkg.sv
// Constants and types for the external bus request and grant arbiter.
// Assumes one peripheral clock domain; all pins arrive asynchronously.

package ebrg_pkg;

	// ==========================================================
	// Port widths
	localparam int ADDR_W = 22;
	localparam int DATA_W = 16;
	localparam int BANK_W = 4;

	// ==========================================================
	// Idle pin levels and reset values
	localparam logic        REQ_IDLE_N  = 1'b1;
	localparam logic        GRANT_OFF_N = 1'b1;
	localparam logic        STROBE_OFF  = 1'b1;
	localparam logic [3:0]  BANK_OFF    = 4'hf;
	localparam logic [21:0] ADDR_RST    = 22'h000000;
	localparam logic [15:0] DATA_RST    = 16'h0000;

	// ==========================================================
	// Arbiter states
	typedef enum logic [1:0] {
		EBRG_OWN     = 2'b00,	// Device drives the port
		EBRG_RELEASE = 2'b01,	// Drivers off, grant not yet given
		EBRG_GRANTED = 2'b10,	// Outside master owns the bus
		EBRG_RECLAIM = 2'b11	// Grant withdrawn, drivers still off
	} ebrg_state_t;

endpackage : ebrg_pkg

// ### design/ebrg_sync.sv
// Two-flop synchroniser for asynchronous levels.
// Assumes the input is a level that stays put for several clock periods.

`timescale 1ns/1ns

module ebrg_sync #(
	parameter int               WIDTH   = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input  wire logic             clk,	// Sampling clock
	input  wire logic             arst_n,	// Asynchronous reset, low active
	input  wire logic [WIDTH-1:0] d,	// Asynchronous input
	output logic      [WIDTH-1:0] q	// Synchronised output
);

	logic [WIDTH-1:0] meta_r;	// Read only by the second stage

	// ==========================================================
	// Two stages
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_r <= RST_VAL;
			q      <= RST_VAL;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end

endmodule : ebrg_sync

// ### design/ebrg_arbiter.sv
// External bus request/grant arbiter and port driver control.
// Assumes core_clk is the peripheral clock and internal requesters sit on it.

`timescale 1ns/1ns

module ebrg_arbiter (
	input  wire logic                           core_clk,	// Peripheral clock, 100 MHz
	input  wire logic                           rstn,	// Power-on reset, low active
	input  wire logic                           master_rst_n,	// Master reset pin, low active
	input  wire logic                           ext_bus_req_n,	// Outside bus request pin
	input  wire logic                           core_req,	// Core wants the port
	input  wire logic                           read_pair_lock,	// Between paired reads
	input  wire logic                           dma_req,	// Peripheral/DMA wants port
	input  wire logic                           excl_core,	// Exclusive core setting
	input  wire logic [ebrg_pkg::ADDR_W-1:0]    int_addr,	// Address from port logic
	input  wire logic [ebrg_pkg::DATA_W-1:0]    int_data,	// Write data from port logic
	input  wire logic                           int_data_en,	// Port logic writes data
	input  wire logic [ebrg_pkg::BANK_W-1:0]    int_bank_sel_n,	// Bank selects
	input  wire logic                           int_boot_sel_n,	// Boot space select
	input  wire logic                           int_io_sel_n,	// I/O space select
	input  wire logic                           int_rd_n,	// Read strobe
	input  wire logic                           int_wr_n,	// Write strobe
	output logic                                bus_grant_n,	// Grant pin, low active
	output logic                                grant_hang_n,	// Held-off access pin
	output logic                                core_stall,	// Stall to the sequencer
	output logic [ebrg_pkg::ADDR_W-1:0]         ext_addr_o,	// Address pin value
	output logic                                ext_addr_oe,	// Address pin enable
	output logic [ebrg_pkg::DATA_W-1:0]         ext_data_o,	// Data pin value
	output logic                                ext_data_oe,	// Data pin enable
	output logic [ebrg_pkg::BANK_W-1:0]         mem_bank_sel_n,	// Bank select pins
	output logic                                boot_space_sel_n,	// Boot select pin
	output logic                                io_space_sel_n,	// I/O select pin
	output logic                                rd_n_o,	// Read strobe pin
	output logic                                wr_n_o,	// Write strobe pin
	output logic                                ctrl_oe	// Selects and strobes enable
);

	// ==========================================================
	// State record
	typedef struct packed {
		ebrg_pkg::ebrg_state_t          st;
		logic                           grant_n;
		logic                           hang_n;
		logic                           stall;
		logic [ebrg_pkg::ADDR_W-1:0]    addr;
		logic                           addr_oe;
		logic [ebrg_pkg::DATA_W-1:0]    data;
		logic                           data_oe;
		logic [ebrg_pkg::BANK_W-1:0]    bank_n;
		logic                           boot_n;
		logic                           io_n;
		logic                           rd_n;
		logic                           wr_n;
		logic                           ctrl_oe;
	} ebrg_regs_t;

	ebrg_regs_t s_r;
	ebrg_regs_t s_nxt;
	logic       rst_n_s;	// Released reset for the whole block
	logic [1:0] pins_s;	// {master reset, bus request}, synchronised
	logic       req_s;	// Outside request active, high
	logic       core_in_rst;	// Master reset held
	logic       int_pending;	// Internal claim on the port

	// ==========================================================
	// Reset release and pin synchronisers
	ebrg_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_rst_sync (
		.clk    (core_clk),
		.arst_n (rstn),
		.d      (1'b1),
		.q      (rst_n_s)
	);

	// Request crosses two flops before any arbiter logic sees it
	ebrg_sync #(.WIDTH(2), .RST_VAL(2'b11)) u_pin_sync (
		.clk    (core_clk),
		.arst_n (rst_n_s),
		.d      ({master_rst_n, ext_bus_req_n}),
		.q      (pins_s)
	);

	// ==========================================================
	// Request decode
	// Master reset silences internal requesters but never the arbiter itself
	assign core_in_rst = !pins_s[1];
	assign req_s       = (pins_s[0] != ebrg_pkg::REQ_IDLE_N);
	// Exclusive setting keeps DMA off the port, yet the outside request is still served
	assign int_pending = !core_in_rst &&
		(core_req || read_pair_lock || (dma_req && !excl_core));

	// ==========================================================
	// Next state
	always_comb begin
		s_nxt = s_r;
		unique case (s_r.st)
			ebrg_pkg::EBRG_OWN: begin
				// Outside request is lowest priority; a read pair holds it off
				if (req_s && !int_pending) begin
					s_nxt.st = ebrg_pkg::EBRG_RELEASE;
				end
			end
			ebrg_pkg::EBRG_RELEASE: begin
				// Drivers are already off here, so grant follows safely
				s_nxt.st = req_s ? ebrg_pkg::EBRG_GRANTED : ebrg_pkg::EBRG_RECLAIM;
			end
			ebrg_pkg::EBRG_GRANTED: begin
				if (!req_s) begin
					s_nxt.st = ebrg_pkg::EBRG_RECLAIM;
				end
			end
			ebrg_pkg::EBRG_RECLAIM: begin
				// One cycle with grant gone and drivers off avoids contention
				s_nxt.st = ebrg_pkg::EBRG_OWN;
			end
		endcase

		// Grant only in the granted state; earliest is the fourth edge
		s_nxt.grant_n = (s_nxt.st == ebrg_pkg::EBRG_GRANTED) ?
			!ebrg_pkg::GRANT_OFF_N : ebrg_pkg::GRANT_OFF_N;

		// Port drivers enabled only while the device owns the bus
		s_nxt.addr_oe = (s_nxt.st == ebrg_pkg::EBRG_OWN);
		s_nxt.ctrl_oe = (s_nxt.st == ebrg_pkg::EBRG_OWN);
		s_nxt.data_oe = (s_nxt.st == ebrg_pkg::EBRG_OWN) && int_data_en;
		s_nxt.addr    = int_addr;
		s_nxt.data    = int_data;
		// Strobes and selects forced idle while off, so a pull-up sees no glitch
		s_nxt.bank_n  = s_nxt.ctrl_oe ? int_bank_sel_n : ebrg_pkg::BANK_OFF;
		s_nxt.boot_n  = s_nxt.ctrl_oe ? int_boot_sel_n : ebrg_pkg::STROBE_OFF;
		s_nxt.io_n    = s_nxt.ctrl_oe ? int_io_sel_n : ebrg_pkg::STROBE_OFF;
		s_nxt.rd_n    = s_nxt.ctrl_oe ? int_rd_n : ebrg_pkg::STROBE_OFF;
		s_nxt.wr_n    = s_nxt.ctrl_oe ? int_wr_n : ebrg_pkg::STROBE_OFF;

		// A core access while the bus is away stalls execution, unless master reset is held
		s_nxt.stall  = core_req && !core_in_rst &&
			(s_nxt.st != ebrg_pkg::EBRG_OWN);
		// Hang reports an internal access held off by the grant
		s_nxt.hang_n = !(int_pending && (s_nxt.st != ebrg_pkg::EBRG_OWN));
	end

	// ==========================================================
	// State register on the peripheral clock
	always_ff @(posedge core_clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			s_r.st      <= ebrg_pkg::EBRG_OWN;
			s_r.grant_n <= ebrg_pkg::GRANT_OFF_N;
			s_r.hang_n  <= ebrg_pkg::GRANT_OFF_N;
			s_r.stall   <= 1'b0;
			s_r.addr    <= ebrg_pkg::ADDR_RST;
			s_r.addr_oe <= 1'b0;
			s_r.data    <= ebrg_pkg::DATA_RST;
			s_r.data_oe <= 1'b0;
			s_r.bank_n  <= ebrg_pkg::BANK_OFF;
			s_r.boot_n  <= ebrg_pkg::STROBE_OFF;
			s_r.io_n    <= ebrg_pkg::STROBE_OFF;
			s_r.rd_n    <= ebrg_pkg::STROBE_OFF;
			s_r.wr_n    <= ebrg_pkg::STROBE_OFF;
			s_r.ctrl_oe <= 1'b0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ==========================================================
	// Outputs, all straight from flops
	assign bus_grant_n      = s_r.grant_n;
	assign grant_hang_n     = s_r.hang_n;
	assign core_stall       = s_r.stall;
	assign ext_addr_o       = s_r.addr;
	assign ext_addr_oe      = s_r.addr_oe;
	assign ext_data_o       = s_r.data;
	assign ext_data_oe      = s_r.data_oe;
	assign mem_bank_sel_n   = s_r.bank_n;
	assign boot_space_sel_n = s_r.boot_n;
	assign io_space_sel_n   = s_r.io_n;
	assign rd_n_o           = s_r.rd_n;
	assign wr_n_o           = s_r.wr_n;
	assign ctrl_oe          = s_r.ctrl_oe;

endmodule : ebrg_arbiter

// ### verif/ebrg_properties.sv
// Pin-level checker for the bus request arbiter.
// Assumes it is bound to ebrg_arbiter and sees only its ports.
`timescale 1ns/1ns
module ebrg_properties (
	input wire logic       core_clk,         // Clock
	input wire logic       rstn,             // Reset, low active
	input wire logic       master_rst_n,     // Master reset pin
	input wire logic       ext_bus_req_n,    // Outside request
	input wire logic       core_req,         // Core request
	input wire logic       read_pair_lock,   // Paired reads
	input wire logic       dma_req,          // DMA request
	input wire logic       excl_core,        // Exclusive core
	input wire logic       bus_grant_n,      // Grant
	input wire logic       grant_hang_n,     // Held-off access
	input wire logic       core_stall,       // Stall
	input wire logic       ext_addr_oe,      // Address enable
	input wire logic       ext_data_oe,      // Data enable
	input wire logic       ctrl_oe,          // Strobe enable
	input wire logic [3:0] mem_bank_sel_n,   // Bank selects
	input wire logic       boot_space_sel_n, // Boot select
	input wire logic       io_space_sel_n,   // I/O select
	input wire logic       rd_n_o,           // Read strobe
	input wire logic       wr_n_o            // Write strobe
);
	// ==========================================================
	// Properties; master reset is synchronised, so stall checks wait it out
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);
	property p_float; !bus_grant_n |-> !ext_addr_oe && !ext_data_oe && !ctrl_oe; endproperty
	a_float: assert property (p_float) else $error("drivers on while granted");
	property p_quiet;
		!ctrl_oe |-> rd_n_o && wr_n_o && boot_space_sel_n && io_space_sel_n
			&& mem_bank_sel_n == 4'hf;
	endproperty
	a_quiet: assert property (p_quiet) else $error("strobe active while released");
	property p_order; $fell(bus_grant_n) |-> $past(!ctrl_oe); endproperty
	a_order: assert property (p_order) else $error("grant before release");
	property p_min3; $fell(bus_grant_n) |-> $past(!ext_bus_req_n, 3); endproperty
	a_min3: assert property (p_min3) else $error("grant too early");
	property p_prio;
		$fell(ctrl_oe) && master_rst_n |->
			$past(!core_req && !read_pair_lock && !(dma_req && !excl_core));
	endproperty
	a_prio: assert property (p_prio) else $error("grant over internal request");
	property p_back;
		$rose(ext_bus_req_n) && !bus_grant_n |-> ##[1:4] (bus_grant_n && !ctrl_oe) ##1 ctrl_oe;
	endproperty
	a_back: assert property (p_back) else $error("bus not returned");
	property p_stall;
		!bus_grant_n && $past(core_req) && master_rst_n && $past(master_rst_n, 3) |-> core_stall;
	endproperty
	a_stall: assert property (p_stall) else $error("no stall while granted");
	property p_hang;
		!bus_grant_n && $past(core_req) && master_rst_n && $past(master_rst_n, 3)
			|-> !grant_hang_n;
	endproperty
	a_hang: assert property (p_hang) else $error("no hang while granted");
endmodule : ebrg_properties
bind ebrg_arbiter ebrg_properties ebrg_properties_i (.core_clk, .rstn, .master_rst_n,
	.ext_bus_req_n, .core_req, .read_pair_lock, .dma_req, .excl_core, .bus_grant_n,
	.grant_hang_n, .core_stall, .ext_addr_oe, .ext_data_oe, .ctrl_oe, .mem_bank_sel_n,
	.boot_space_sel_n, .io_space_sel_n, .rd_n_o, .wr_n_o);

// ### verif/ebrg_ext_master.sv
// Outside bus master that borrows the port on command.
// Assumes want changes off the rising edge.
`timescale 1ns/1ns
module ebrg_ext_master (
	input  wire logic core_clk,     // Clock
	input  wire logic want,         // Bench asks for the bus
	output logic      ext_bus_req_n // Request pin, low active
);
	// ==========================================================
	// Request held for as long as the bus is wanted, never dropped early
	initial ext_bus_req_n = 1'b1;
	always @(posedge core_clk) begin
		ext_bus_req_n <= !want;
	end
endmodule : ebrg_ext_master

// ### verif/tb_top.sv
// Self-checking bench for the bus request arbiter.
// Assumes the checker is bound in; inputs change at falling edges.
`timescale 1ns/1ns
module tb_top;
	logic                        core_clk, rstn, master_rst_n, want, int_data_en;
	logic                        core_req, read_pair_lock, dma_req, excl_core;
	logic                        bus_grant_n, grant_hang_n, core_stall, ctrl_oe, ext_bus_req_n;
	logic                        ext_addr_oe, ext_data_oe, boot_space_sel_n, io_space_sel_n;
	logic                        rd_n_o, wr_n_o;
	logic [3:0]                  mem_bank_sel_n;
	logic [ebrg_pkg::ADDR_W-1:0] int_addr, ext_addr_o;
	logic [ebrg_pkg::DATA_W-1:0] int_data, ext_data_o;
	int                          miscompares = 0, n_tests = 0, cyc = 0, n;
	ebrg_arbiter ebrg_arbiter_i (.core_clk, .rstn, .master_rst_n, .ext_bus_req_n, .core_req,
		.read_pair_lock, .dma_req, .excl_core, .int_addr, .int_data, .int_data_en,
		.int_bank_sel_n(4'ha), .int_boot_sel_n(1'b0), .int_io_sel_n(1'b1), .int_rd_n(1'b0),
		.int_wr_n(1'b1), .bus_grant_n, .grant_hang_n, .core_stall, .ext_addr_o, .ext_addr_oe,
		.ext_data_o, .ext_data_oe, .mem_bank_sel_n, .boot_space_sel_n, .io_space_sel_n,
		.rd_n_o, .wr_n_o, .ctrl_oe);
	ebrg_ext_master ebrg_ext_master_i (.core_clk, .want, .ext_bus_req_n);
	// ==========================================================
	// Clock and hang guard; a run needs well under 400 cycles
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 2000) begin
			miscompares++;
			print_verdict();
		end
	end
	// ==========================================================
	// Shared tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic grab(output int k);
		want = 1'b1;
		k = 0;
		while (bus_grant_n !== 1'b0 && k < 20) begin
			@(negedge core_clk);
			k++;
		end
	endtask : grab
	task automatic drop(output int k);
		want = 1'b0;
		k = 0;
		while (bus_grant_n !== 1'b1 && k < 20) begin
			@(negedge core_clk);
			k++;
		end
	endtask : drop
	// ==========================================================
	// Scenarios
	task automatic t_basic();
		grab(n);
		chk(n >= 4 && n <= 5, 1);
		chk({ext_addr_oe, ext_data_oe, ctrl_oe, rd_n_o, wr_n_o, mem_bank_sel_n}, 9'h03f);
		chk({boot_space_sel_n, io_space_sel_n}, 2'h3);
		core_req = 1'b1;
		repeat (2) @(negedge core_clk);
		chk({core_stall, grant_hang_n}, 2'b10);
		drop(n);
		chk(n <= 5, 1);
		@(negedge core_clk);
		chk({ctrl_oe, core_stall, grant_hang_n, mem_bank_sel_n}, 7'h5a);
		chk(ext_addr_o, int_addr);
		chk(ext_data_o, int_data);
		chk({ext_addr_oe, ext_data_oe, boot_space_sel_n, io_space_sel_n}, 4'hd);
		core_req = 1'b0;
		$display("test basic done");
	endtask : t_basic
	task automatic t_prio(input logic [3:0] v, input logic blk);
		{core_req, read_pair_lock, dma_req, excl_core} = v;
		want = 1'b1;
		repeat (10) @(negedge core_clk);
		chk(bus_grant_n, blk);
		{core_req, read_pair_lock, dma_req, excl_core} = 4'h0;
		grab(n);
		chk(bus_grant_n, 0);
		drop(n);
		@(negedge core_clk);
		$display("test priority %h done", v);
	endtask : t_prio
	task automatic t_mrst();
		master_rst_n = 1'b0;
		core_req = 1'b1;
		repeat (4) @(negedge core_clk);
		grab(n);
		chk({bus_grant_n, core_stall}, 2'b00);
		drop(n);
		core_req = 1'b0;
		repeat (2) @(negedge core_clk);
		master_rst_n = 1'b1;
		repeat (4) @(negedge core_clk);
		$display("test master reset done");
	endtask : t_mrst
	// ==========================================================
	// Closing report and main sequence
	task automatic print_verdict();
		$display("comparisons %0d miscompares %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : print_verdict
	initial begin
		{rstn, want, core_req, read_pair_lock, dma_req, excl_core} = 6'h00;
		master_rst_n = 1'b1;
		int_addr = 22'h15a5a5;
		int_data = 16'hc3c3;
		int_data_en = 1'b1;
		repeat (3) @(negedge core_clk);
		rstn = 1'b1;
		repeat (4) @(negedge core_clk);
		t_basic();
		t_prio(4'h8, 1'b1);
		t_prio(4'h4, 1'b1);
		t_prio(4'h2, 1'b1);
		t_prio(4'h3, 1'b0);
		t_mrst();
		print_verdict();
	end
endmodule : tb_top
